// File: rlc_consts.svh
// Purpose: constants for the redriver lane control block
// Assumes: 100 MHz clk_sys, straps arrive as comparator thermometer codes
// Notes: timing figures are kept in their own unit, counts derived
//
// Notes on behaviour
// - mode strap at L0 means settings come from the strap inputs.
// - first equalization pair drives channels 0-3, second pair channels 4-7.
// - equalization index is four times high level plus low level, 0..15.
// - first gain strap sets channels 0-3, second sets 4-7; L3 default.
// - detection starts at power-up, power-down release in pin mode, software.
// - any change on either crosspoint select restarts detection.
// - first power-down input owns group 0-3, second owns group 4-7.
// - detect config L0 with power-down low: no detection, always 50 ohm.
// - with detection enabled, poll termination about every 150 us.
// - detection enabled: high impedance before detection, 50 ohm after.
// - only first power-down high: reset group 0-3 path, high impedance.
// - only second power-down high: reset group 4-7 path, high impedance.
// - both power-down inputs high: standby, all channels high impedance.
// - detect config L1 to L3, power-down low: active PCI Express mode.
// - detect config L0, power-down low: active buffer mode, detection off, equalizer on.
// - four 2x2 crosspoints, one select per group, straight or crossed.
// - each four-level strap decodes to L0..L3, L3 being a floating pin.
// - four-level straps are sampled once at power-up, later changes ignored.
// - the mode strap is also accepted while running.
// - mode strap at L1 selects self-load from external memory.
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH

// strap comparator thermometer codes
`define RLC_THERMO_L0 3'h0
`define RLC_THERMO_L1 3'h1
`define RLC_THERMO_L2 3'h3
`define RLC_THERMO_L3 3'h7

// decoded level codes
`define RLC_LVL_L0 2'h0
`define RLC_LVL_L1 2'h1
`define RLC_LVL_L2 2'h2
`define RLC_LVL_L3 2'h3

// timing
`define RLC_CLK_PERIOD_NS 10
`define RLC_POLL_US 150
`define RLC_POLL_CYCLES ((`RLC_POLL_US * 1000) / `RLC_CLK_PERIOD_NS)

// reset values
`define RLC_EQ_RST 4'h0
`define RLC_LVL_RST 2'h3

`endif

// File: rlc_far_end.sv
// Purpose: far-end receiver termination seen by the probe
// Assumes: a probe pulse excites the sense comparator
// Notes: DELAY sets how slowly the sense answers, 1 or more
`timescale 1ns/1ps
module rlc_far_end #(
   parameter int DELAY = 1
) (
   input wire logic clk_sys, // clock
   input wire logic resetn, // reset
   input wire logic probe, // probe pulse
   input wire logic present, // termination fitted
   output logic sense // termination seen
);
   logic [7:0] cnt_q;
   // sense lasts one cycle only, so a late check misses it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) cnt_q <= 8'h00;
      else if (probe) cnt_q <= DELAY[7:0];
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
   end
   assign sense = present && (cnt_q == 8'h01);
endmodule : rlc_far_end

// File: rlc_lane_control.sv
// Purpose: strap decode, receiver detect, power-down and crosspoint control
// Assumes: straps are thermometer codes from divider comparators
// Notes: two channel groups, a covers 0-3 and b covers 4-7
`timescale 1ns/1ps
`include "rlc_consts.svh"

module rlc_lane_control
   import rlc_pkg::*;
#(
   parameter int POLL_CYCLES = `RLC_POLL_CYCLES
) (
   input wire logic clk_sys, // 100 MHz system clock
   input wire logic resetn, // async reset, low active
   input wire logic [2:0] mode_strap, // mode strap, thermometer
   input wire logic [2:0] eq_high_level_grp_a, // eq high strap, group a
   input wire logic [2:0] eq_low_level_grp_a, // eq low strap, group a
   input wire logic [2:0] eq_high_level_grp_b, // eq high strap, group b
   input wire logic [2:0] eq_low_level_grp_b, // eq low strap, group b
   input wire logic [2:0] flat_gain_grp_a, // gain strap, group a
   input wire logic [2:0] flat_gain_grp_b, // gain strap, group b
   input wire logic [2:0] termination_detect_cfg, // detect config strap
   input wire logic powerdown_grp_a, // power-down, group a
   input wire logic powerdown_grp_b, // power-down, group b
   input wire logic xpoint_select_grp_a, // crosspoint select, group a
   input wire logic xpoint_select_grp_b, // crosspoint select, group b
   input wire logic [3:0] sw_eq_index_grp_a, // programmed eq, group a
   input wire logic [3:0] sw_eq_index_grp_b, // programmed eq, group b
   input wire logic [1:0] sw_flat_gain_grp_a, // programmed gain, a
   input wire logic [1:0] sw_flat_gain_grp_b, // programmed gain, b
   input wire logic sw_detect_restart, // one-cycle restart pulse
   input wire logic term_sense_grp_a, // far-end termination seen, a
   input wire logic term_sense_grp_b, // far-end termination seen, b
   output logic [3:0] eq_index_grp_a, // linear_equalizer index, a
   output logic [3:0] eq_index_grp_b, // linear_equalizer index, b
   output logic [1:0] gain_level_grp_a, // flat gain level, a
   output logic [1:0] gain_level_grp_b, // flat gain level, b
   output logic [1:0] mode_level, // decoded mode level
   output logic pin_mode, // settings from straps
   output logic self_load_mode, // load from external memory
   output logic detect_probe_grp_a, // termination probe pulse, a
   output logic detect_probe_grp_b, // termination probe pulse, b
   output logic term_50ohm_grp_a, // 1: 50 ohm, 0: high impedance
   output logic term_50ohm_grp_b, // 1: 50 ohm, 0: high impedance
   output logic path_reset_grp_a, // signal path held in reset, a
   output logic path_reset_grp_b, // signal path held in reset, b
   output logic standby, // power-saving standby
   output logic active_pcie, // active PCI Express mode
   output logic active_buffer, // active buffer mode
   output logic xpoint_cross_grp_a, // 1: crossed, 0: straight, a
   output logic xpoint_cross_grp_b // 1: crossed, 0: straight, b
);

   localparam int CW = $clog2(POLL_CYCLES + 1);
   localparam logic [CW-1:0] POLL_LAST = CW'(POLL_CYCLES - 1);
   localparam int NSTRAP = 6;

   // thermometer to level; a broken code reads as floating
   function automatic rlc_level_type lvl_decode(input logic [2:0] t);
      rlc_level_type l;
      l = `RLC_LVL_L3;
      case (t)
         `RLC_THERMO_L0: l = `RLC_LVL_L0;
         `RLC_THERMO_L1: l = `RLC_LVL_L1;
         `RLC_THERMO_L2: l = `RLC_LVL_L2;
         `RLC_THERMO_L3: l = `RLC_LVL_L3;
         default: l = `RLC_LVL_L3;
      endcase
      return l;
   endfunction : lvl_decode

   // strap order: eq high a, eq low a, eq high b, eq low b, gain a, gain b
   logic [2:0] strap_raw [NSTRAP];
   rlc_level_type strap_lvl [NSTRAP];
   rlc_level_type strap_q [NSTRAP];
   rlc_level_type det_cfg_q;
   logic captured_q;

   assign strap_raw[0] = eq_high_level_grp_a;
   assign strap_raw[1] = eq_low_level_grp_a;
   assign strap_raw[2] = eq_high_level_grp_b;
   assign strap_raw[3] = eq_low_level_grp_b;
   assign strap_raw[4] = flat_gain_grp_a;
   assign strap_raw[5] = flat_gain_grp_b;

   // straps caught once, on the first edge after reset release
   genvar s;
   generate
      for (s = 0; s < NSTRAP; s++) begin : g_strap
         assign strap_lvl[s] = lvl_decode(strap_raw[s]);
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               strap_q[s] <= `RLC_LVL_RST;
            end else if (!captured_q) begin
               strap_q[s] <= strap_lvl[s];
            end
         end
      end
   endgenerate

   // capture flag and detect config strap, frozen after power-up
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         captured_q <= 1'b0;
         det_cfg_q <= `RLC_LVL_RST;
      end else if (!captured_q) begin
         captured_q <= 1'b1;
         det_cfg_q <= lvl_decode(termination_detect_cfg);
      end
   end

   // mode strap stays live, unlike the rest
   rlc_level_type mode_d;
   rlc_level_type mode_q;
   wire pin_mode_d = (mode_d == `RLC_LVL_L0);
   wire self_load_d = (mode_d == `RLC_LVL_L1);
   assign mode_d = lvl_decode(mode_strap);

   // settings source: straps in pin mode, programmed values otherwise
   wire [3:0] strap_eq_a = {strap_q[0], strap_q[1]};
   wire [3:0] strap_eq_b = {strap_q[2], strap_q[3]};
   wire [3:0] eq_a_d = pin_mode_d ? strap_eq_a : sw_eq_index_grp_a;
   wire [3:0] eq_b_d = pin_mode_d ? strap_eq_b : sw_eq_index_grp_b;
   wire [1:0] gain_a_d = pin_mode_d ? strap_q[4] : sw_flat_gain_grp_a;
   wire [1:0] gain_b_d = pin_mode_d ? strap_q[5] : sw_flat_gain_grp_b;

   logic [3:0] eq_a_q;
   logic [3:0] eq_b_q;
   logic [1:0] gain_a_q;
   logic [1:0] gain_b_q;
   logic pin_mode_q;
   logic self_load_q;

   // registered settings; gain resets to the floating default
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode_q <= `RLC_LVL_RST;
         eq_a_q <= `RLC_EQ_RST;
         eq_b_q <= `RLC_EQ_RST;
         gain_a_q <= `RLC_LVL_RST;
         gain_b_q <= `RLC_LVL_RST;
         pin_mode_q <= 1'b0;
         self_load_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         eq_a_q <= eq_a_d;
         eq_b_q <= eq_b_d;
         gain_a_q <= gain_a_d;
         gain_b_q <= gain_b_d;
         pin_mode_q <= pin_mode_d;
         self_load_q <= self_load_d;
      end
   end

   // crosspoint selects, and the previous value to spot a change
   logic [1:0] xsel_q;
   wire [1:0] xsel_in = {xpoint_select_grp_b, xpoint_select_grp_a};
   wire xsel_change = captured_q && (xsel_in != xsel_q);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         xsel_q <= 2'h0;
      end else begin
         xsel_q <= xsel_in;
      end
   end

   // group-wide conditions
   wire [1:0] pd_in = {powerdown_grp_b, powerdown_grp_a};
   wire [1:0] term_in = {term_sense_grp_b, term_sense_grp_a};
   wire det_en = (det_cfg_q != `RLC_LVL_L0);
   wire both_pd = &pd_in;
   wire no_pd = ~|pd_in;

   logic [1:0] pd_q;
   logic [1:0] probe_q;
   logic [1:0] term50_q;
   logic [1:0] preset_q;

   // per group detect machine; a group in power-down forgets its result
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_grp
         rlc_det_state_type st_q;
         rlc_det_state_type st_d;
         logic [CW-1:0] cnt_q;
         logic [CW-1:0] cnt_d;
         // power-down release only counts as a trigger in pin mode
         wire pd_release = pd_q[g] && !pd_in[g] && pin_mode_d;
         wire restart = pd_release || sw_detect_restart || xsel_change;
         wire wait_done = (cnt_q == POLL_LAST);

         // next state; power-down wins over every trigger
         always_comb begin
            st_d = st_q;
            cnt_d = cnt_q;
            if (!captured_q || pd_in[g]) begin
               st_d = RLC_ST_OFF;
               cnt_d = '0;
            end else if (!det_en) begin
               st_d = RLC_ST_BUF;
               cnt_d = '0;
            end else if (restart) begin
               st_d = RLC_ST_POLL;
               cnt_d = '0;
            end else begin
               case (st_q)
                  RLC_ST_OFF: begin
                     st_d = RLC_ST_POLL;
                  end
                  RLC_ST_BUF: begin
                     st_d = RLC_ST_POLL;
                  end
                  RLC_ST_POLL: begin
                     st_d = RLC_ST_SENSE;
                     cnt_d = '0;
                  end
                  RLC_ST_SENSE: begin
                     // count the gap from the probe onward
                     if (term_in[g]) begin
                        st_d = RLC_ST_DONE;
                     end else if (wait_done) begin
                        st_d = RLC_ST_POLL;
                     end else begin
                        cnt_d = cnt_q + CW'(1);
                     end
                  end
                  RLC_ST_DONE: begin
                     st_d = RLC_ST_DONE;
                  end
                  default: begin
                     st_d = RLC_ST_OFF;
                  end
               endcase
            end
         end

         // state, counter and per-group outputs
         always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               st_q <= RLC_ST_OFF;
               cnt_q <= '0;
               pd_q[g] <= 1'b0;
               probe_q[g] <= 1'b0;
               term50_q[g] <= 1'b0;
               preset_q[g] <= 1'b0;
            end else begin
               st_q <= st_d;
               cnt_q <= cnt_d;
               pd_q[g] <= pd_in[g];
               probe_q[g] <= (st_d == RLC_ST_POLL);
               term50_q[g] <= (st_d == RLC_ST_DONE) ||
                              (st_d == RLC_ST_BUF);
               preset_q[g] <= pd_in[g];
            end
         end
      end
   endgenerate

   // device-wide mode flags
   logic standby_q;
   logic pcie_q;
   logic buffer_q;
   logic [1:0] xcross_q;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         standby_q <= 1'b0;
         pcie_q <= 1'b0;
         buffer_q <= 1'b0;
         xcross_q <= 2'h0;
      end else begin
         standby_q <= both_pd;
         pcie_q <= captured_q && no_pd && det_en;
         buffer_q <= captured_q && no_pd && !det_en;
         xcross_q <= xsel_in;
      end
   end

   // outputs, each straight from a flop
   assign eq_index_grp_a = eq_a_q;
   assign eq_index_grp_b = eq_b_q;
   assign gain_level_grp_a = gain_a_q;
   assign gain_level_grp_b = gain_b_q;
   assign mode_level = mode_q;
   assign pin_mode = pin_mode_q;
   assign self_load_mode = self_load_q;
   assign detect_probe_grp_a = probe_q[0];
   assign detect_probe_grp_b = probe_q[1];
   assign term_50ohm_grp_a = term50_q[0];
   assign term_50ohm_grp_b = term50_q[1];
   assign path_reset_grp_a = preset_q[0];
   assign path_reset_grp_b = preset_q[1];
   assign standby = standby_q;
   assign active_pcie = pcie_q;
   assign active_buffer = buffer_q;
   assign xpoint_cross_grp_a = xcross_q[0];
   assign xpoint_cross_grp_b = xcross_q[1];

endmodule : rlc_lane_control

// File: rlc_lane_control_props.sv
// Purpose: port-level checks for the lane control block
// Assumes: one clock domain, resetn async low
// Notes: up_q hides the first edges after reset
`timescale 1ns/1ps
module rlc_lane_control_props (
   input wire logic clk_sys, // clock
   input wire logic resetn, // reset
   input wire logic [2:0] mode_strap, // mode strap
   input wire logic powerdown_grp_a, // pd a
   input wire logic powerdown_grp_b, // pd b
   input wire logic xpoint_select_grp_a, // sel a
   input wire logic xpoint_select_grp_b, // sel b
   input wire logic sw_detect_restart, // restart pulse
   input wire logic term_sense_grp_a, // sense a
   input wire logic [3:0] eq_index_grp_a, // eq a
   input wire logic [1:0] mode_level, // mode
   input wire logic pin_mode, // pin mode
   input wire logic self_load_mode, // self load
   input wire logic detect_probe_grp_b, // probe b
   input wire logic term_50ohm_grp_a, // term a
   input wire logic path_reset_grp_a, // path a
   input wire logic path_reset_grp_b, // path b
   input wire logic standby, // standby
   input wire logic active_buffer, // buffer mode
   input wire logic xpoint_cross_grp_a // cross a
);
   logic [1:0] up_q;
   wire up_w = (up_q == 2'h3);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // settle counter, reset values are not judged
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) up_q <= 2'h0;
      else if (!up_w) up_q <= up_q + 2'h1;
   end
   // restart causes seen at the pins; they may bring a probe early
   logic [2:0] prev_q;
   wire kick_w = sw_detect_restart ||
      ({powerdown_grp_b, xpoint_select_grp_b, xpoint_select_grp_a} != prev_q);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) prev_q <= 3'h0;
      else prev_q <= {powerdown_grp_b, xpoint_select_grp_b, xpoint_select_grp_a};
   end
   // thermometer to level, odd codes read as floating
   function automatic logic [1:0] lvl(input logic [2:0] t);
      return (t == 3'h0) ? 2'h0 : (t == 3'h1) ? 2'h1 :
         (t == 3'h3) ? 2'h2 : 2'h3;
   endfunction : lvl
   property p_path_a;
      up_w |-> path_reset_grp_a == $past(powerdown_grp_a);
   endproperty
   a_path_a: assert property (p_path_a) else $error("path a");
   property p_path_b;
      up_w |-> path_reset_grp_b == $past(powerdown_grp_b);
   endproperty
   a_path_b: assert property (p_path_b) else $error("path b");
   property p_hiz;
      up_w && $past(powerdown_grp_a) |-> !term_50ohm_grp_a;
   endproperty
   a_hiz: assert property (p_hiz) else $error("term a on");
   property p_stby;
      up_w |-> standby == $past(powerdown_grp_a && powerdown_grp_b);
   endproperty
   a_stby: assert property (p_stby) else $error("standby");
   property p_xpt;
      up_w |-> xpoint_cross_grp_a == $past(xpoint_select_grp_a);
   endproperty
   a_xpt: assert property (p_xpt) else $error("cross a");
   property p_probe;
      detect_probe_grp_b |=> (!detect_probe_grp_b || $past(kick_w)) [*3];
   endproperty
   a_probe: assert property (p_probe) else $error("probe b");
   property p_mode;
      up_w |-> mode_level == lvl($past(mode_strap));
   endproperty
   a_mode: assert property (p_mode) else $error("mode");
   property p_pin;
      up_w |-> pin_mode == (mode_level == 2'h0) &&
         self_load_mode == (mode_level == 2'h1);
   endproperty
   a_pin: assert property (p_pin) else $error("pin");
   property p_eq;
      up_w && pin_mode && $past(pin_mode) |-> $stable(eq_index_grp_a);
   endproperty
   a_eq: assert property (p_eq) else $error("eq moved");
   property p_term;
      up_w && $rose(term_50ohm_grp_a) && !active_buffer
         |-> $past(term_sense_grp_a);
   endproperty
   a_term: assert property (p_term) else $error("term a");
endmodule : rlc_lane_control_props
bind rlc_lane_control rlc_lane_control_props rlc_lane_control_props_inst (
   .clk_sys, .resetn, .mode_strap, .powerdown_grp_a, .powerdown_grp_b,
   .xpoint_select_grp_a, .xpoint_select_grp_b, .sw_detect_restart,
   .term_sense_grp_a, .eq_index_grp_a, .mode_level,
   .pin_mode, .self_load_mode, .detect_probe_grp_b, .term_50ohm_grp_a,
   .path_reset_grp_a, .path_reset_grp_b, .standby, .active_buffer,
   .xpoint_cross_grp_a);

// File: rlc_pkg.sv
// Purpose: types shared by the redriver lane control block
// Assumes: nothing beyond the constants header
// Notes: detect states are one-hot
package rlc_pkg;

   typedef logic [1:0] rlc_level_type;

   typedef enum logic [4:0] {
      RLC_ST_OFF = 5'h01,
      RLC_ST_BUF = 5'h02,
      RLC_ST_POLL = 5'h04,
      RLC_ST_SENSE = 5'h08,
      RLC_ST_DONE = 5'h10
   } rlc_det_state_type;

endpackage : rlc_pkg

// File: test_redriver_lane_control.sv
// Purpose: self-checking bench for the lane control block
// Assumes: poll count shortened to 20 cycles, a probe every 21 cycles
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module test_redriver_lane_control;
   logic clk_sys = 1'b0;
   logic resetn;
   logic [2:0] mode_strap, eq_high_level_grp_a, eq_low_level_grp_a;
   logic [2:0] eq_high_level_grp_b, eq_low_level_grp_b, flat_gain_grp_a;
   logic [2:0] flat_gain_grp_b, termination_detect_cfg;
   logic powerdown_grp_a, powerdown_grp_b, sw_detect_restart;
   logic xpoint_select_grp_a, xpoint_select_grp_b, present_a, present_b;
   logic [3:0] sw_eq_index_grp_a, sw_eq_index_grp_b;
   logic [1:0] sw_flat_gain_grp_a, sw_flat_gain_grp_b;
   wire term_sense_grp_a, term_sense_grp_b;
   wire [3:0] eq_index_grp_a, eq_index_grp_b;
   wire [1:0] gain_level_grp_a, gain_level_grp_b, mode_level;
   wire pin_mode, self_load_mode, detect_probe_grp_a, detect_probe_grp_b;
   wire term_50ohm_grp_a, term_50ohm_grp_b, path_reset_grp_a;
   wire path_reset_grp_b, standby, active_pcie, active_buffer;
   wire xpoint_cross_grp_a, xpoint_cross_grp_b;
   int fail_count = 0;
   int checks_done = 0;
   rlc_lane_control #(.POLL_CYCLES(20)) rlc_lane_control_inst (.clk_sys,
      .resetn, .mode_strap, .eq_high_level_grp_a, .eq_low_level_grp_a,
      .eq_high_level_grp_b, .eq_low_level_grp_b, .flat_gain_grp_a,
      .flat_gain_grp_b, .termination_detect_cfg, .powerdown_grp_a,
      .powerdown_grp_b, .xpoint_select_grp_a, .xpoint_select_grp_b,
      .sw_eq_index_grp_a, .sw_eq_index_grp_b, .sw_flat_gain_grp_a,
      .sw_flat_gain_grp_b, .sw_detect_restart, .term_sense_grp_a,
      .term_sense_grp_b, .eq_index_grp_a, .eq_index_grp_b, .gain_level_grp_a,
      .gain_level_grp_b, .mode_level, .pin_mode, .self_load_mode,
      .detect_probe_grp_a, .detect_probe_grp_b, .term_50ohm_grp_a,
      .term_50ohm_grp_b, .path_reset_grp_a, .path_reset_grp_b, .standby,
      .active_pcie, .active_buffer, .xpoint_cross_grp_a, .xpoint_cross_grp_b);
   // prompt far end on group a, slow one on group b
   rlc_far_end #(.DELAY(1)) rlc_far_end_a_inst (.clk_sys, .resetn,
      .probe(detect_probe_grp_a), .present(present_a),
      .sense(term_sense_grp_a));
   rlc_far_end #(.DELAY(4)) rlc_far_end_b_inst (.clk_sys, .resetn,
      .probe(detect_probe_grp_b), .present(present_b),
      .sense(term_sense_grp_b));
   always #5 clk_sys = ~clk_sys;
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chk_bit
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   task do_reset;
      resetn = 1'b0;
      repeat (4) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (3) @(negedge clk_sys);
   endtask : do_reset
   // bounded wait for a group's termination to reach a level
   task wait_term(input logic grp, input logic want);
      for (int i = 0; i < 300; i++) begin
         if ((grp ? term_50ohm_grp_b : term_50ohm_grp_a) === want) break;
         @(negedge clk_sys);
      end
      chk_bit(grp ? term_50ohm_grp_b : term_50ohm_grp_a, want);
   endtask : wait_term
   task t_straps;
      chk({4'h0, eq_index_grp_a}, 8'h0B);
      chk({4'h0, eq_index_grp_b}, 8'h04);
      chk({6'h00, gain_level_grp_a}, 8'h00);
      chk({6'h00, gain_level_grp_b}, 8'h03);
      chk_bit(pin_mode, 1'b1);
      eq_high_level_grp_a = 3'h0;
      repeat (3) @(negedge clk_sys);
      chk({4'h0, eq_index_grp_a}, 8'h0B);
   endtask : t_straps
   task t_detect;
      int n;
      chk_bit(active_pcie, 1'b1);
      wait_term(1'b0, 1'b1);
      chk_bit(term_50ohm_grp_b, 1'b0);
      for (n = 0; n < 50 && detect_probe_grp_b !== 1'b1; n++)
         @(negedge clk_sys);
      @(negedge clk_sys);
      for (n = 1; n < 99 && detect_probe_grp_b !== 1'b1; n++)
         @(negedge clk_sys);
      chk(n[7:0], 8'h15);
   endtask : t_detect
   task t_powerdown;
      powerdown_grp_a = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_bit(path_reset_grp_a, 1'b1);
      chk_bit(term_50ohm_grp_a, 1'b0);
      chk_bit(path_reset_grp_b, 1'b0);
      powerdown_grp_b = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk_bit(standby, 1'b1);
      chk_bit(path_reset_grp_b, 1'b1);
      repeat (20000) @(negedge clk_sys);
      powerdown_grp_a = 1'b0;
      powerdown_grp_b = 1'b0;
      wait_term(1'b0, 1'b1);
   endtask : t_powerdown
   task t_xsel;
      xpoint_select_grp_a = 1'b1;
      xpoint_select_grp_b = 1'b1;
      @(negedge clk_sys);
      chk_bit(detect_probe_grp_a, 1'b1);
      @(negedge clk_sys);
      chk_bit(xpoint_cross_grp_a, 1'b1);
      chk_bit(xpoint_cross_grp_b, 1'b1);
      chk_bit(term_50ohm_grp_a, 1'b0);
      wait_term(1'b0, 1'b1);
   endtask : t_xsel
   task t_soft;
      mode_strap = 3'h1;
      repeat (2) @(negedge clk_sys);
      chk_bit(self_load_mode, 1'b1);
      chk({4'h0, eq_index_grp_a}, 8'h05);
      sw_detect_restart = 1'b1;
      @(negedge clk_sys);
      sw_detect_restart = 1'b0;
      wait_term(1'b0, 1'b0);
      wait_term(1'b0, 1'b1);
      // every mode level, ending back in pin mode
      for (int i = 3; i >= 0; i--) begin
         mode_strap = 3'h7 >> (3 - i);
         repeat (2) @(negedge clk_sys);
         chk({6'h00, mode_level}, i[7:0]);
      end
      chk({4'h0, eq_index_grp_a}, 8'h0B);
   endtask : t_soft
   task t_buffer;
      int n;
      termination_detect_cfg = 3'h0;
      do_reset();
      chk_bit(active_buffer, 1'b1);
      chk_bit(term_50ohm_grp_a & term_50ohm_grp_b, 1'b1);
      n = 0;
      repeat (60) begin
         @(negedge clk_sys);
         n += detect_probe_grp_a | detect_probe_grp_b;
      end
      chk(n[7:0], 8'h00);
   endtask : t_buffer
   // cut a hang short well beyond the expected run length
   initial begin
      #400000;
      fail_count++;
      final_report();
   end
   initial begin
      {resetn, powerdown_grp_a, powerdown_grp_b, sw_detect_restart} = 4'h0;
      {xpoint_select_grp_a, xpoint_select_grp_b, present_b} = 3'h0;
      present_a = 1'b1;
      mode_strap = 3'h0;
      eq_high_level_grp_a = 3'h3;
      eq_low_level_grp_a = 3'h7;
      eq_high_level_grp_b = 3'h1;
      eq_low_level_grp_b = 3'h0;
      flat_gain_grp_a = 3'h0;
      flat_gain_grp_b = 3'h7;
      termination_detect_cfg = 3'h7;
      sw_eq_index_grp_a = 4'h5;
      sw_eq_index_grp_b = 4'hA;
      sw_flat_gain_grp_a = 2'h1;
      sw_flat_gain_grp_b = 2'h2;
      do_reset();
      t_straps();
      t_detect();
      t_powerdown();
      t_xsel();
      t_soft();
      t_buffer();
      final_report();
   end
endmodule : test_redriver_lane_control
